/* File: rtl/wdrc_pkg.sv */
// package for the watchdog and reset control block
package wdrc_pkg;
  // register byte addresses on the avalon bus
  localparam logic [3:0] WDRC_ADDR_CTRL   = 4'h0;
  localparam logic [3:0] WDRC_ADDR_CAUSE  = 4'h4;
  localparam logic [3:0] WDRC_ADDR_STAT   = 4'h8;
  // control field positions and reset values
  localparam int         WDRC_GUARD_LSB   = 3;
  localparam logic [7:0] WDRC_CTRL_RST    = 8'h53;
  localparam logic [4:0] WDRC_GUARD_EN_A  = 5'h0a;
  localparam logic [4:0] WDRC_GUARD_EN_B  = 5'h15;
  // cause register bit positions
  localparam int         WDRC_BIT_WDC     = 0;
  localparam int         WDRC_BIT_LOW     = 2;
  localparam int         WDRC_BIT_RSTREG  = 3;
  // status register bit positions
  localparam int         WDRC_BIT_EXPIRY  = 0;
  localparam int         WDRC_BIT_PDOWN   = 1;
  // core clock and slow oscillator
  localparam int         WDRC_CLK_HZ      = 20000000;
  localparam int         WDRC_SLOW_HZ     = 32000;
  // software reset delay in microseconds, and in core cycles
  localparam int         WDRC_SRST_US     = 16;
  localparam int         WDRC_SRST_CYC    =
    (WDRC_SRST_US * (WDRC_CLK_HZ / 1000000));
  // pulse width of the reset outputs in cycles
  localparam logic [3:0] WDRC_RST_PULSE   = 4'h4;
  // bus carrier
  typedef struct packed {
    logic [3:0] address;
    logic       read;
    logic       write;
    logic [7:0] writedata;
  } wdrc_bus_s;
  // reset action kinds
  typedef enum logic [1:0] {
    WDRC_ACT_NONE = 2'b00,
    WDRC_ACT_FULL = 2'b01,
    WDRC_ACT_PCSP = 2'b10
  } wdrc_act_e;
endpackage : wdrc_pkg

/* File: rtl/wdrc_top.sv */
// watchdog timer with reset cause flags and reset generation
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Operation
// - watchdog counts only while guard field holds 01010 or 10101
// - any other guard code resets the device after a fixed delay, sets flag
// - guard field powers up at 01010 so the watchdog runs
// - period codes 000..110 select ratios 2^8,10,12,14,15,16,17
// - longest time-out uses ratio 2^18 of the slow clock
// - control cause flag set by illegal guard reset, cleared by zero write or power-on reset
// - overflow while running gives full reset and sets expiry flag
// - overflow in sleep or idle sets expiry, resets only pc and sp
// - counter cleared by illegal guard write, clear instruction, power-down
// - both the clear and the power-down instruction clear the counter by software instruction
// - cause register bits 7..4 and 1 read as zero
// - power-on reset forces the program counter to zero
// - power-on sets all port data and control registers high
// - low-supply detection triggers a full device reset
// - counter runs from the slow oscillator divided by selected ratio
// - power-down sets power-down flag, clears expiry, clears watchdog
// - power-down flag cleared on power-up and by the clear instruction
module wdrc_top
  import wdrc_pkg::*;
#(
  parameter int SRST_CYC = WDRC_SRST_CYC
)(
  // clock and power-on reset
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  // avalon-mm slave
  input  wire logic [3:0] avs_address,
  input  wire logic       avs_read,
  input  wire logic       avs_write,
  input  wire logic [7:0] avs_writedata,
  output logic      [7:0] avs_readdata,
  output logic            avs_waitrequest,
  // pins and core events
  input  wire logic       slow_clk_pin,
  input  wire logic       low_supply_pin,
  input  wire logic       clear_instr,
  input  wire logic       power_down_instr,
  input  wire logic       low_power_mode,
  // reset actions
  output logic            full_reset_r,
  output logic            pcsp_reset_r,
  output logic            power_on_init_r
);

  //////////////////////////////////////////////////////////////////////////
  // input synchronisers; first stage feeds only the second
  logic [1:0] slow_sync_r;
  logic [1:0] low_sync_r;
  logic       slow_prev_r;
  logic       low_prev_r;
  logic       slow_tick;
  logic       low_event;

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      slow_sync_r <= 2'h0;
      low_sync_r  <= 2'h0;
      slow_prev_r <= 1'b0;
      low_prev_r  <= 1'b0;
    end
    else
    begin
      slow_sync_r <= {slow_sync_r[0], slow_clk_pin};
      low_sync_r  <= {low_sync_r[0], low_supply_pin};
      slow_prev_r <= slow_sync_r[1];
      low_prev_r  <= low_sync_r[1];
    end
  end

  // rising edges; low supply gives one full reset per drop
  assign slow_tick = slow_sync_r[1] & ~slow_prev_r;
  assign low_event = low_sync_r[1] & ~low_prev_r;

  //////////////////////////////////////////////////////////////////////////
  // bus decode; one wait cycle so readdata comes from a flip-flop
  wdrc_bus_s bus;
  logic      ack;
  logic      ctrl_wr;
  logic      cause_wr;

  assign bus      = {avs_address, avs_read, avs_write, avs_writedata};
  assign ack      = ~avs_waitrequest;
  assign ctrl_wr  = bus.write & ack & (bus.address == WDRC_ADDR_CTRL);
  assign cause_wr = bus.write & ack & (bus.address == WDRC_ADDR_CAUSE);

  // waitrequest drops for one cycle per access, straight from a flop
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      avs_waitrequest <= 1'b1;
    else
      avs_waitrequest <= ~((bus.read | bus.write) & avs_waitrequest);
  end

  //////////////////////////////////////////////////////////////////////////
  // control register
  logic [7:0] ctrl_r;
  logic [4:0] guard;
  logic [2:0] period_select;
  logic       guard_ok;

  assign guard         = ctrl_r[7:WDRC_GUARD_LSB];
  assign period_select = ctrl_r[2:0];
  assign guard_ok      = (guard == WDRC_GUARD_EN_A) ||
                         (guard == WDRC_GUARD_EN_B);

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      ctrl_r <= WDRC_CTRL_RST;
    else if (ctrl_wr)
      ctrl_r <= bus.writedata;
  end

  //////////////////////////////////////////////////////////////////////////
  // divider length: index of the top bit of the ratio
  logic [4:0] top_bit;

  always_comb
  begin
    unique case (period_select)
      3'h0: top_bit = 5'h08;
      3'h1: top_bit = 5'h0a;
      3'h2: top_bit = 5'h0c;
      3'h3: top_bit = 5'h0e;
      3'h4: top_bit = 5'h0f;
      3'h5: top_bit = 5'h10;
      3'h6: top_bit = 5'h11;
      3'h7: top_bit = 5'h12;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // watchdog counter; overflow when the selected bit is reached
  logic [18:0] wdt_cnt_r;
  logic        overflow;
  logic        wdt_clear;

  assign overflow  = guard_ok & slow_tick & wdt_cnt_r[top_bit];
  assign wdt_clear = clear_instr | power_down_instr | ~guard_ok
                     | overflow;

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      wdt_cnt_r <= 19'h0;
    else if (wdt_clear)
      wdt_cnt_r <= 19'h0;
    else if (slow_tick)
      wdt_cnt_r <= wdt_cnt_r + 19'h1;
  end

  //////////////////////////////////////////////////////////////////////////
  // software reset delay from an illegal guard code
  logic [31:0] srst_cnt_r;
  logic        srst_fire;

  assign srst_fire = ~guard_ok && (srst_cnt_r == 32'(SRST_CYC - 1));

  always_ff @(posedge core_clk)
  begin
    if (sys_rst || guard_ok)
      srst_cnt_r <= 32'h0;
    else if (!srst_fire)
      srst_cnt_r <= srst_cnt_r + 32'h1;
  end

  //////////////////////////////////////////////////////////////////////////
  // reset cause flags; hardware set wins over software clear
  logic wdc_flag_r;
  logic low_flag_r;
  logic rstreg_flag_r;

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      wdc_flag_r <= 1'b0;
    else if (srst_fire)
      wdc_flag_r <= 1'b1;
    else if (cause_wr && !bus.writedata[WDRC_BIT_WDC])
      wdc_flag_r <= 1'b0;
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      low_flag_r <= 1'b0;
    else if (low_event)
      low_flag_r <= 1'b1;
    else if (cause_wr && !bus.writedata[WDRC_BIT_LOW])
      low_flag_r <= 1'b0;
  end

  // register-control reset source lives elsewhere; flag only cleared here
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      rstreg_flag_r <= 1'b0;
    else if (cause_wr && !bus.writedata[WDRC_BIT_RSTREG])
      rstreg_flag_r <= 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////
  // status flags: expiry and power-down
  logic expiry_r;
  logic pdown_r;

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      expiry_r <= 1'b0;
    else if (overflow)
      expiry_r <= 1'b1;
    else if (power_down_instr)
      expiry_r <= 1'b0;
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      pdown_r <= 1'b0;
    else if (power_down_instr)
      pdown_r <= 1'b1;
    else if (clear_instr)
      pdown_r <= 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////
  // reset action selection and pulse stretch
  wdrc_act_e  act;
  logic [3:0] pulse_cnt_r;
  wdrc_act_e  pulse_kind_r;

  always_comb
  begin
    if (srst_fire || low_event || (overflow && !low_power_mode))
      act = WDRC_ACT_FULL;
    else if (overflow)
      act = WDRC_ACT_PCSP;
    else
      act = WDRC_ACT_NONE;
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      pulse_cnt_r  <= 4'h0;
      pulse_kind_r <= WDRC_ACT_NONE;
    end
    else if (act != WDRC_ACT_NONE)
    begin
      pulse_cnt_r  <= WDRC_RST_PULSE;
      pulse_kind_r <= act;
    end
    else if (pulse_cnt_r != 4'h0)
      pulse_cnt_r  <= pulse_cnt_r - 4'h1;
  end

  // registered reset outputs; power-on init held while sys_rst is high
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      full_reset_r    <= 1'b1;
      pcsp_reset_r    <= 1'b0;
      power_on_init_r <= 1'b1;
    end
    else
    begin
      full_reset_r    <= (pulse_cnt_r != 4'h0) &&
                         (pulse_kind_r == WDRC_ACT_FULL);
      pcsp_reset_r    <= (pulse_cnt_r != 4'h0) &&
                         (pulse_kind_r == WDRC_ACT_PCSP);
      power_on_init_r <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read data, captured during the wait cycle, valid on the acknowledge cycle
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      avs_readdata <= 8'h0;
    else if (bus.read && !ack)
    begin
      unique case (bus.address)
        WDRC_ADDR_CTRL:  avs_readdata <= ctrl_r;
        WDRC_ADDR_CAUSE: avs_readdata <= {4'h0, rstreg_flag_r, low_flag_r,
                                          1'b0, wdc_flag_r};
        WDRC_ADDR_STAT:  avs_readdata <= {6'h0, pdown_r, expiry_r};
        default:         avs_readdata <= 8'h0;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks
  guard_reset_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    srst_fire |-> ##1 wdc_flag_r ##1 full_reset_r)
    else $error("illegal guard did not reset and flag");
  count_gate_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    !guard_ok |=> wdt_cnt_r == 19'h0)
    else $error("watchdog counted with illegal guard");
  sleep_kind_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    overflow && low_power_mode && !srst_fire && !low_event
      |-> ##2 pcsp_reset_r && !full_reset_r)
    else $error("sleep overflow gave wrong reset");
  run_kind_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    overflow && !low_power_mode |=> expiry_r ##1 full_reset_r)
    else $error("run overflow missing full reset");
  pdown_flags_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    power_down_instr && !overflow |=> pdown_r && !expiry_r
      && wdt_cnt_r == 19'h0)
    else $error("power-down effects missing");
  pdown_clear_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    clear_instr && !power_down_instr |=> !pdown_r)
    else $error("clear did not drop power-down flag");
  cause_zero_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    !avs_waitrequest |-> !(avs_address == WDRC_ADDR_CAUSE && avs_read)
      || (avs_readdata[7:4] == 4'h0 && !avs_readdata[1]))
    else $error("unimplemented cause bits not zero");
  low_reset_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    low_event |=> low_flag_r ##1 full_reset_r)
    else $error("low supply did not reset");
  wdc_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    wdc_flag_r && !(cause_wr && !avs_writedata[WDRC_BIT_WDC])
      |=> wdc_flag_r)
    else $error("control cause flag dropped without write");
endmodule : wdrc_top

/* File: bench/watchdog_reset_control_test.sv */
// self-checking bench for the watchdog and reset control block
`timescale 1ns/1ps
module watchdog_reset_control_test;
  import wdrc_pkg::*;
  localparam int SRST = 4;
  // clock, reset and bus
  logic       core_clk;
  logic       sys_rst;
  logic [3:0] avs_address;
  logic       avs_read;
  logic       avs_write;
  logic [7:0] avs_writedata;
  logic [7:0] avs_readdata;
  logic       avs_waitrequest;
  // pins, events and reset actions
  logic       slow_clk_pin;
  logic       low_supply_pin;
  logic       clear_instr;
  logic       power_down_instr;
  logic       low_power_mode;
  logic       full_reset_r;
  logic       pcsp_reset_r;
  logic       power_on_init_r;
  int         n_fail;
  int         comparisons;
  int         cyc;
  logic [1:0] slow_div_r;
  logic [7:0] q;
  int         n;
  wdrc_top #(.SRST_CYC(SRST)) dut_u (
    .core_clk(core_clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .slow_clk_pin(slow_clk_pin),
    .low_supply_pin(low_supply_pin), .clear_instr(clear_instr),
    .power_down_instr(power_down_instr), .low_power_mode(low_power_mode),
    .full_reset_r(full_reset_r), .pcsp_reset_r(pcsp_reset_r),
    .power_on_init_r(power_on_init_r));
  //////////////////////////////////////////////////////////////////////////
  // 50 ns clock
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // slow oscillator stand-in: one rising edge per four core cycles
  always @(posedge core_clk)
  begin
    slow_div_r   <= slow_div_r + 2'h1;
    slow_clk_pin <= slow_div_r[1];
    cyc          <= cyc + 1;
    if (cyc == 60000)
    begin
      n_fail++;
      final_report();
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // shared tasks, all entered just after a rising edge
  task automatic check(input string nm, input logic [7:0] s, e);
    comparisons++;
    if (s !== e)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : check
  task automatic ack();
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
  endtask : ack
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    ack();
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask : wr
  task automatic rd(input logic [3:0] a);
    avs_address <= a;
    avs_read <= 1'b1;
    ack();
    q = avs_readdata;
    avs_read <= 1'b0;
    @(posedge core_clk);
  endtask : rd
  // one-cycle instruction pulse; pd selects power-down over clear
  task automatic instr(input bit pd);
    if (pd) power_down_instr <= 1'b1;
    else clear_instr <= 1'b1;
    @(posedge core_clk);
    power_down_instr <= 1'b0;
    clear_instr <= 1'b0;
    @(posedge core_clk);
  endtask : instr
  // bounded wait for a reset request; sel picks the pc/sp one
  task automatic wait_rst(input bit sel, input int lim);
    n = 0;
    while (((sel ? pcsp_reset_r : full_reset_r) !== 1'b1) && n < lim)
    begin
      @(posedge core_clk);
      n++;
    end
    check("reset_seen", 8'(n < lim), 8'h01);
  endtask : wait_rst
  //////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    rd(WDRC_ADDR_CTRL);
    check("ctrl_por", q, WDRC_CTRL_RST);
    rd(WDRC_ADDR_CAUSE);
    check("cause_por", q, 8'h00);
    rd(4'hc);
    check("unmapped", q, 8'h00);
    wr(WDRC_ADDR_CTRL, 8'ha8);
    rd(WDRC_ADDR_CTRL);
    check("ctrl_rw", q, 8'ha8);
  endtask : t_reset
  // illegal guard code fires a delayed reset and a sticky flag
  task automatic t_illegal();
    wr(WDRC_ADDR_CTRL, 8'h00);
    wait_rst(1'b0, SRST + 12);
    check("srst_delay", 8'(n >= SRST), 8'h01);
    wr(WDRC_ADDR_CTRL, 8'h50);
    rd(WDRC_ADDR_CAUSE);
    check("cause_wdc", q, 8'h01);
    wr(WDRC_ADDR_CAUSE, 8'hff);
    rd(WDRC_ADDR_CAUSE);
    check("cause_one_w", q, 8'h01);
    wr(WDRC_ADDR_CAUSE, 8'h00);
    rd(WDRC_ADDR_CAUSE);
    check("cause_clr", q, 8'h00);
  endtask : t_illegal
  // time-out with period code c, in normal or low-power mode
  task automatic t_expire(input logic [2:0] c, input bit lp);
    int r;
    r = 1 << (8 + 2 * c); // ratio for codes 0..3 only
    low_power_mode <= lp;
    wr(WDRC_ADDR_CTRL, {WDRC_GUARD_EN_A, c});
    instr(1'b0);
    wait_rst(lp, r * 4 + 40);
    check("ratio_low", 8'(n >= r * 4 - 16), 8'h01);
    check("other_rst", lp ? full_reset_r : pcsp_reset_r, 8'h00);
    repeat (8) @(posedge core_clk);
    low_power_mode <= 1'b0;
    rd(WDRC_ADDR_STAT);
    check("expiry", q, 8'h01);
    instr(1'b1);
    rd(WDRC_ADDR_STAT);
    check("pdown", q, 8'h02);
    instr(1'b0);
    rd(WDRC_ADDR_STAT);
    check("pdown_clr", q, 8'h00);
  endtask : t_expire
  // periodic clearing, by either instruction, holds off the reset
  task automatic t_keep();
    int seen;
    seen = 0;
    wr(WDRC_ADDR_CTRL, 8'h50);
    instr(1'b0);
    for (int i = 0; i < 8; i++)
    begin
      repeat (600)
      begin
        @(posedge core_clk);
        if (full_reset_r === 1'b1) seen = 1;
      end
      instr(i[0]);
    end
    check("no_expire", 8'(seen), 8'h00);
  endtask : t_keep
  // low-supply detection forces a full reset and sets its flag
  task automatic t_low();
    low_supply_pin <= 1'b1;
    wait_rst(1'b0, 20);
    low_supply_pin <= 1'b0;
    rd(WDRC_ADDR_CAUSE);
    check("cause_low", q, 8'h04);
    wr(WDRC_ADDR_CAUSE, 8'h00);
  endtask : t_low
  //////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic final_report();
    if (n_fail == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report
  // main sequence
  initial
  begin
    n_fail = 0;
    comparisons = 0;
    cyc = 0;
    slow_div_r = 2'h0;
    slow_clk_pin = 1'b0;
    sys_rst = 1'b1;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 8'h00;
    low_supply_pin = 1'b0;
    clear_instr = 1'b0;
    power_down_instr = 1'b0;
    low_power_mode = 1'b0;
    repeat (10) @(posedge core_clk);
    check("por_hold", power_on_init_r, 8'h01);
    check("full_hold", full_reset_r, 8'h01);
    check("wait_hold", avs_waitrequest, 8'h01);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    @(posedge core_clk);
    check("por_init", power_on_init_r, 8'h00);
    check("full_rel", full_reset_r, 8'h00);
    t_reset();
    t_illegal();
    t_expire(3'h0, 1'b0);
    t_expire(3'h1, 1'b1);
    t_expire(3'h2, 1'b0);
    t_keep();
    t_low();
    final_report();
  end
endmodule : watchdog_reset_control_test
